// [verilog/ipl_pkg.sv]
/*
 Constants, field layout and types of the interrupt level arbiter.
 Assumes one 40 MHz clock and APB with 32-bit data; word index times four is the byte address.
*/
package ipl_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned SRC_N  = 18;
    localparam int unsigned LVL_N  = 3;

    typedef logic [1:0]       ipl_field_t;
    typedef logic [LVL_N-1:0] ipl_lvl_t;

    // Word indices
    localparam logic [7:0] IDX_FLASH_CLOCK = 8'h01;
    localparam logic [7:0] IDX_SERIAL      = 8'h02;
    localparam logic [7:0] IDX_ADC_TIMER   = 8'h03;
    localparam logic [7:0] IDX_PWM_ADC     = 8'h04;
    localparam logic [7:0] IDX_STATUS      = 8'h20;
    localparam logic [7:0] IDX_MASK        = 8'h21;

    localparam logic [15:0]      RST_PRIO = 16'h0000;
    localparam logic [SRC_N-1:0] RST_MASK = 18'h00000;

    // Writable bits; the rest hold zero
    localparam logic [15:0] WMASK_FLASH_CLOCK = 16'h0003;
    localparam logic [15:0] WMASK_SERIAL      = 16'hF3FF;
    localparam logic [15:0] WMASK_ADC_TIMER   = 16'hFFF0;
    localparam logic [15:0] WMASK_PWM_ADC     = 16'h00FF;

    localparam ipl_field_t FLD_OFF = 2'h0;
    localparam ipl_field_t FLD_L0  = 2'h1;
    localparam ipl_field_t FLD_L1  = 2'h2;
    localparam ipl_field_t FLD_L2  = 2'h3;

    // Field positions (low bit)
    localparam int unsigned POS_CLOCK_LOCK_EVENT    = 0;
    localparam int unsigned POS_ASYNC_RX_FULL       = 14;
    localparam int unsigned POS_ASYNC_RX_ERROR      = 12;
    localparam int unsigned POS_ASYNC_TX_IDLE       = 8;
    localparam int unsigned POS_ASYNC_TX_EMPTY      = 6;
    localparam int unsigned POS_SYNC_SERIAL_TX      = 4;
    localparam int unsigned POS_SYNC_SERIAL_RX      = 2;
    localparam int unsigned POS_PORT_A_PIN          = 0;
    localparam int unsigned POS_CONVERTER_A_DONE    = 14;
    localparam int unsigned POS_TIMER_CH3           = 12;
    localparam int unsigned POS_TIMER_CH2           = 10;
    localparam int unsigned POS_TIMER_CH1           = 8;
    localparam int unsigned POS_TIMER_CH0           = 6;
    localparam int unsigned POS_TWO_WIRE_ADDR_MATCH = 4;
    localparam int unsigned POS_MODULATOR_FAULT     = 6;
    localparam int unsigned POS_MODULATOR_RELOAD    = 4;
    localparam int unsigned POS_CONVERTER_ZERO_LIM  = 2;
    localparam int unsigned POS_CONVERTER_B_DONE    = 0;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        return {idx[ADDR_W-3:0], 2'b00};
    endfunction
endpackage

// [verilog/ipl_src_route.sv]
/*
 Maps one source's level field and request onto one-hot core levels.
 Assumes the request is already in the system clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module ipl_src_route (
    input  wire logic                i_req,
    input  wire ipl_pkg::ipl_field_t i_field,
    output logic                     o_on,
    output ipl_pkg::ipl_lvl_t        o_lvl
);
    import ipl_pkg::*;

    always_comb begin
        o_on  = i_req && (i_field != FLD_OFF);
        o_lvl = '0;
        case (i_field)
            FLD_L0:  o_lvl = 3'h1;
            FLD_L1:  o_lvl = 3'h2;
            FLD_L2:  o_lvl = 3'h4;
            default: o_lvl = '0;
        endcase
        if (!i_req) begin
            o_lvl = '0;
        end
    end
endmodule
`default_nettype wire

// [verilog/ipl_event_flags.sv]
/*
 Sticky event flags, set on a rising forwarded request, cleared by write-one.
 Assumes the clear strobe lasts one cycle per completed APB write.
*/
`timescale 1ns/10ps
`default_nettype none
module ipl_event_flags #(
    parameter int unsigned N = 18
) (
    input  wire logic         i_mclk,
    input  wire logic         i_sys_rst,
    input  wire logic [N-1:0] i_event,
    input  wire logic         i_clr_we,
    input  wire logic [N-1:0] i_clr_data,
    output logic      [N-1:0] o_status
);
    import ipl_pkg::*;

    typedef struct packed {
        logic [N-1:0] prev;
        logic [N-1:0] status;
    } ipl_flag_s;

    ipl_flag_s r_q;
    ipl_flag_s r_d;

    always_comb begin
        r_d = r_q;
        r_d.prev = i_event;
        // Set beats a clear in the same cycle
        if (i_clr_we) begin
            r_d.status = r_q.status & ~i_clr_data;
        end
        r_d.status = r_d.status | (i_event & ~r_q.prev);
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign o_status = r_q.status;
endmodule
`default_nettype wire

// [verilog/ipl_interrupt_arbiter.sv]
/*
 Interrupt level arbiter: priority fields, APB slave, event flags, level outputs.
 Assumes peripheral requests are levels in the system clock domain
 and an APB master that holds each request until pready.
*/
`timescale 1ns/10ps
`default_nettype none
module ipl_interrupt_arbiter (
    input  wire logic                        i_mclk,
    input  wire logic                        i_sys_rst,
    input  wire logic                        i_psel,
    input  wire logic                        i_penable,
    input  wire logic                        i_pwrite,
    input  wire logic [ipl_pkg::ADDR_W-1:0]  i_paddr,
    input  wire logic [31:0]                 i_pwdata,
    output logic      [31:0]                 o_prdata,
    output logic                             o_pready,
    output logic                             o_pslverr,
    input  wire logic [ipl_pkg::SRC_N-1:0]   i_src_req,
    output logic      [ipl_pkg::LVL_N-1:0]   o_core_lvl_req,
    output logic                             o_irq
);
    import ipl_pkg::*;

    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic [15:0]       priority_flash_clock_group;
        logic [15:0]       priority_serial_group;
        logic [15:0]       priority_adc_timer_group;
        logic [15:0]       priority_pwm_adc_group;
        logic [SRC_N-1:0]  mask;
        ipl_lvl_t          lvl;
        logic              irq;
    } ipl_top_s;

    ipl_top_s               r_q;
    ipl_top_s               r_d;
    ipl_field_t [SRC_N-1:0] fields;
    ipl_lvl_t   [SRC_N-1:0] src_lvl;
    logic       [SRC_N-1:0] src_on;
    logic       [SRC_N-1:0] status;
    logic                   acc;
    logic                   wr_take;
    logic                   clr_we;
    logic                   hit;
    logic       [31:0]      rd_data;
    ipl_lvl_t               lvl_any;

    // Second register
    assign fields[0]  = r_q.priority_flash_clock_group[POS_CLOCK_LOCK_EVENT +: 2];

    // Third register
    assign fields[1]  = r_q.priority_serial_group[POS_ASYNC_RX_FULL +: 2];
    assign fields[2]  = r_q.priority_serial_group[POS_ASYNC_RX_ERROR +: 2];
    assign fields[3]  = r_q.priority_serial_group[POS_ASYNC_TX_IDLE +: 2];
    assign fields[4]  = r_q.priority_serial_group[POS_ASYNC_TX_EMPTY +: 2];
    assign fields[5]  = r_q.priority_serial_group[POS_SYNC_SERIAL_TX +: 2];
    assign fields[6]  = r_q.priority_serial_group[POS_SYNC_SERIAL_RX +: 2];
    assign fields[7]  = r_q.priority_serial_group[POS_PORT_A_PIN +: 2];

    // Fourth register
    assign fields[8]  = r_q.priority_adc_timer_group[POS_CONVERTER_A_DONE +: 2];
    assign fields[9]  = r_q.priority_adc_timer_group[POS_TIMER_CH3 +: 2];
    assign fields[10] = r_q.priority_adc_timer_group[POS_TIMER_CH2 +: 2];
    assign fields[11] = r_q.priority_adc_timer_group[POS_TIMER_CH1 +: 2];
    assign fields[12] = r_q.priority_adc_timer_group[POS_TIMER_CH0 +: 2];
    assign fields[13] = r_q.priority_adc_timer_group[POS_TWO_WIRE_ADDR_MATCH +: 2];

    // Fifth register
    assign fields[14] = r_q.priority_pwm_adc_group[POS_MODULATOR_FAULT +: 2];
    assign fields[15] = r_q.priority_pwm_adc_group[POS_MODULATOR_RELOAD +: 2];
    assign fields[16] = r_q.priority_pwm_adc_group[POS_CONVERTER_ZERO_LIM +: 2];
    assign fields[17] = r_q.priority_pwm_adc_group[POS_CONVERTER_B_DONE +: 2];

    for (genvar g = 0; g < SRC_N; g++) begin : g_src
        ipl_src_route u_route (
            .i_req   (i_src_req[g]),
            .i_field (fields[g]),
            .o_on    (src_on[g]),
            .o_lvl   (src_lvl[g])
        );
    end

    // Only enabled sources raise flags, so a disabled one stays silent
    ipl_event_flags #(
        .N (SRC_N)
    ) u_flags (
        .i_mclk     (i_mclk),
        .i_sys_rst  (i_sys_rst),
        .i_event    (src_on),
        .i_clr_we   (clr_we),
        .i_clr_data (i_pwdata[SRC_N-1:0]),
        .o_status   (status)
    );

    // One wait state: data are registered in the same cycle as pready and read zero outside it
    assign acc     = i_psel && i_penable;
    assign wr_take = acc && i_pwrite && r_q.pready;
    assign clr_we  = wr_take && (i_paddr == byte_addr(IDX_STATUS));

    always_comb begin
        hit     = 1'b1;
        rd_data = '0;
        if (i_paddr == byte_addr(IDX_FLASH_CLOCK)) begin
            rd_data[15:0] = r_q.priority_flash_clock_group;
        end else if (i_paddr == byte_addr(IDX_SERIAL)) begin
            rd_data[15:0] = r_q.priority_serial_group;
        end else if (i_paddr == byte_addr(IDX_ADC_TIMER)) begin
            rd_data[15:0] = r_q.priority_adc_timer_group;
        end else if (i_paddr == byte_addr(IDX_PWM_ADC)) begin
            rd_data[15:0] = r_q.priority_pwm_adc_group;
        end else if (i_paddr == byte_addr(IDX_STATUS)) begin
            rd_data[SRC_N-1:0] = status;
        end else if (i_paddr == byte_addr(IDX_MASK)) begin
            rd_data[SRC_N-1:0] = r_q.mask;
        end else begin
            hit = 1'b0;
        end
    end

    always_comb begin
        r_d         = r_q;
        lvl_any     = '0;
        r_d.pready  = acc && !r_q.pready;
        r_d.prdata  = '0;
        r_d.pslverr = 1'b0;
        if (acc && !r_q.pready) begin
            r_d.prdata  = i_pwrite ? 32'h0000_0000 : rd_data;
            r_d.pslverr = !hit;
        end
        if (wr_take) begin
            if (i_paddr == byte_addr(IDX_FLASH_CLOCK)) begin
                r_d.priority_flash_clock_group = i_pwdata[15:0] & WMASK_FLASH_CLOCK;
            end else if (i_paddr == byte_addr(IDX_SERIAL)) begin
                r_d.priority_serial_group = i_pwdata[15:0] & WMASK_SERIAL;
            end else if (i_paddr == byte_addr(IDX_ADC_TIMER)) begin
                r_d.priority_adc_timer_group = i_pwdata[15:0] & WMASK_ADC_TIMER;
            end else if (i_paddr == byte_addr(IDX_PWM_ADC)) begin
                r_d.priority_pwm_adc_group = i_pwdata[15:0] & WMASK_PWM_ADC;
            end else if (i_paddr == byte_addr(IDX_MASK)) begin
                r_d.mask = i_pwdata[SRC_N-1:0];
            end
        end
        for (int k = 0; k < SRC_N; k++) begin
            lvl_any = lvl_any | src_lvl[k];
        end
        r_d.lvl = lvl_any;
        r_d.irq = |(status & r_q.mask);
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            r_q                            <= '0;
            r_q.priority_flash_clock_group <= RST_PRIO;
            r_q.priority_serial_group      <= RST_PRIO;
            r_q.priority_adc_timer_group   <= RST_PRIO;
            r_q.priority_pwm_adc_group     <= RST_PRIO;
            r_q.mask                       <= RST_MASK;
        end else begin
            r_q <= r_d;
        end
    end

    assign o_prdata       = r_q.prdata;
    assign o_pready       = r_q.pready;
    assign o_pslverr      = r_q.pslverr;
    assign o_core_lvl_req = r_q.lvl;
    assign o_irq          = r_q.irq;

    // Checks
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_setup;
        i_psel && !i_penable;
    endsequence

    sequence s_access;
        i_psel && i_penable;
    endsequence

    sequence s_wr_serial;
        i_psel && i_penable && i_pwrite && o_pready &&
            (i_paddr == byte_addr(IDX_SERIAL));
    endsequence

    AST_APB_ONE_WAIT: assert property (
        s_setup ##1 s_access |-> !o_pready ##1 o_pready)
        else $error("pready not on second access cycle");

    AST_RESET_OFF: assert property (
        $past(i_sys_rst) |-> (r_q.priority_flash_clock_group == 16'h0000 &&
            r_q.priority_serial_group == 16'h0000 &&
            r_q.priority_adc_timer_group == 16'h0000 &&
            r_q.priority_pwm_adc_group == 16'h0000 && o_core_lvl_req == 3'h0))
        else $error("priority fields not off after reset");

    AST_TOP_LEVEL_CAP: assert property (
        (r_q.priority_pwm_adc_group[1:0] == 2'h3 && i_src_req[17])
        |=> (o_core_lvl_req[2] && !o_core_lvl_req[0] || $past(i_src_req[16:0]) != 0))
        else $error("code 11 not mapped to level 2");

    AST_CLOCK_LOCK: assert property (
        (r_q.priority_flash_clock_group[1:0] == 2'h2 && i_src_req[0]) |=> o_core_lvl_req[1])
        else $error("clock lock source not at level 1");

    AST_SERIAL_WRITE: assert property (
        s_wr_serial |=> (r_q.priority_serial_group[15:12] == $past(i_pwdata[15:12]) &&
            r_q.priority_serial_group[9:6] == $past(i_pwdata[9:6])))
        else $error("serial group fields not written");

    AST_PORT_A: assert property (
        (r_q.priority_serial_group[1:0] == 2'h1 && i_src_req[7]) |=> o_core_lvl_req[0])
        else $error("port A source not at level 0");

    AST_TIMER0: assert property (
        (r_q.priority_adc_timer_group[7:6] == 2'h2 && i_src_req[12]) |=> o_core_lvl_req[1])
        else $error("timer 0 source not at level 1");

    AST_TWO_WIRE: assert property (
        (r_q.priority_adc_timer_group[5:4] == 2'h3 && i_src_req[13]) |=> o_core_lvl_req[2])
        else $error("address match source not at level 2");

    AST_MOD_FAULT: assert property (
        (r_q.priority_pwm_adc_group[7:6] == 2'h1 && i_src_req[14]) |=> o_core_lvl_req[0])
        else $error("modulator fault not at level 0");

    AST_ZERO_LIMIT: assert property (
        (r_q.priority_pwm_adc_group[3:2] == 2'h2 && i_src_req[16]) |=> o_core_lvl_req[1])
        else $error("zero/limit source not at level 1");

    AST_RESERVED_ZERO: assert property (
        s_wr_serial ##1 1'b1 |-> (r_q.priority_serial_group[11:10] == 2'h0 &&
            r_q.priority_adc_timer_group[3:0] == 4'h0 &&
            r_q.priority_pwm_adc_group[15:8] == 8'h00))
        else $error("reserved bits not zero");

    AST_CONV_B: assert property (
        (r_q.priority_pwm_adc_group[1:0] == 2'h1 && i_src_req[17]) |=> o_core_lvl_req[0])
        else $error("converter B source not at level 0");

    AST_DISABLED_SILENT: assert property (
        (r_q.priority_flash_clock_group == 16'h0000 && r_q.priority_serial_group == 16'h0000 &&
            r_q.priority_adc_timer_group == 16'h0000 &&
            r_q.priority_pwm_adc_group == 16'h0000) |=> (o_core_lvl_req == 3'h0))
        else $error("disabled source forwarded");

    AST_RX_FULL: assert property (
        (r_q.priority_serial_group[15:14] == 2'h3 && i_src_req[1]) |=> o_core_lvl_req[2])
        else $error("receiver full source not at level 2");

    AST_RX_ERROR: assert property (
        (r_q.priority_serial_group[13:12] == 2'h2 && i_src_req[2]) |=> o_core_lvl_req[1])
        else $error("receiver error source not at level 1");

    AST_SYNC_RX: assert property (
        (r_q.priority_serial_group[3:2] == 2'h2 && i_src_req[6]) |=> o_core_lvl_req[1])
        else $error("sync receiver source not at level 1");

    AST_CONV_A: assert property (
        (r_q.priority_adc_timer_group[15:14] == 2'h1 && i_src_req[8]) |=> o_core_lvl_req[0])
        else $error("converter A source not at level 0");

    AST_TIMER3: assert property (
        (r_q.priority_adc_timer_group[13:12] == 2'h3 && i_src_req[9]) |=> o_core_lvl_req[2])
        else $error("timer 3 source not at level 2");

    AST_MOD_RELOAD: assert property (
        (r_q.priority_pwm_adc_group[5:4] == 2'h3 && i_src_req[15]) |=> o_core_lvl_req[2])
        else $error("modulator reload not at level 2");

    // No request, no level, whatever the fields say
    AST_IDLE_SOURCES: assert property (
        (i_src_req == '0) |=> (o_core_lvl_req == 3'h0))
        else $error("level raised with no request");

    // Bus answer shape
    AST_PREADY_PULSE: assert property (
        o_pready |=> !o_pready)
        else $error("pready held longer than one cycle");

    AST_PRDATA_IDLE: assert property (
        !o_pready |-> (o_prdata == 32'h0000_0000))
        else $error("read data not zero outside pready");

    AST_SLVERR_READY: assert property (
        o_pslverr |-> o_pready)
        else $error("pslverr without pready");

    // Unmapped writes must leave every register alone
    sequence s_unmapped_wr;
        wr_take && !hit;
    endsequence

    AST_UNMAPPED_WRITE: assert property (
        s_unmapped_wr |=> ($stable(r_q.priority_flash_clock_group) &&
            $stable(r_q.priority_serial_group) && $stable(r_q.priority_adc_timer_group) &&
            $stable(r_q.priority_pwm_adc_group) && $stable(r_q.mask)))
        else $error("unmapped write changed a register");

    // Flags: a new enabled request edge sets, a write-one clears
    AST_EVENT_SETS: assert property (
        (src_on[7] && !$past(src_on[7])) |=> status[7])
        else $error("request edge did not set its flag");

    AST_FLAG_CLEAR: assert property (
        (clr_we && i_pwdata[7] && !src_on[7]) |=> !status[7])
        else $error("write-one did not clear the flag");

    // Irq trails the unmasked flags by one cycle
    AST_IRQ_HIGH: assert property (
        ((status & r_q.mask) != '0) |=> o_irq)
        else $error("irq low with an unmasked flag set");

    AST_IRQ_LOW: assert property (
        ((status & r_q.mask) == '0) |=> !o_irq)
        else $error("irq high with no unmasked flag");
endmodule
`default_nettype wire

// [verif/ipl_periph_model.sv]
/*
 Peripheral side of the arbiter: request lines and the core's level input.
 Assumes the bench commands request levels in the system clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module ipl_periph_model (
    input  wire logic                      i_mclk,
    input  wire logic [ipl_pkg::SRC_N-1:0] i_req_cmd,
    input  wire logic [ipl_pkg::LVL_N-1:0] i_core_lvl,
    output logic      [ipl_pkg::SRC_N-1:0] o_src_req,
    output logic      [ipl_pkg::LVL_N-1:0] o_lvl_seen
);
    import ipl_pkg::*;
    // Requests are levels launched off the clock, as a peripheral flop would
    always_ff @(posedge i_mclk) begin
        o_src_req  <= i_req_cmd;
        o_lvl_seen <= i_core_lvl;
    end
endmodule
`default_nettype wire

// [verif/tb.sv]
/*
 Self-checking bench: APB register checks, per-source level routing, status and irq.
 Assumes the arbiter answers APB with one wait state and levels one cycle late.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ipl_pkg::*;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [17:0] cmd = 18'h00000;
    logic [17:0] src_req;
    logic [2:0]  core_lvl;
    logic [2:0]  lvl_seen;
    logic        irq;
    logic [31:0] rd;
    logic        er;
    int          err_count = 0;
    int          checks = 0;
    int          cyc = 0;
    // Register index and field low bit of each source, in request bit order
    int ridx [18] = '{1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 4, 4, 4, 4};
    int rpos [18] = '{0, 14, 12, 8, 6, 4, 2, 0, 14, 12, 10, 8, 6, 4, 6, 4, 2, 0};
    logic [31:0] wmask [5] = '{32'h0, 32'h00000003, 32'h0000F3FF, 32'h0000FFF0, 32'h000000FF};

    always #12.5 mclk = ~mclk;

    ipl_interrupt_arbiter ipl_interrupt_arbiter_inst (
        .i_mclk         (mclk),
        .i_sys_rst      (sys_rst),
        .i_psel         (psel),
        .i_penable      (penable),
        .i_pwrite       (pwrite),
        .i_paddr        (paddr),
        .i_pwdata       (pwdata),
        .o_prdata       (prdata),
        .o_pready       (pready),
        .o_pslverr      (pslverr),
        .i_src_req      (src_req),
        .o_core_lvl_req (core_lvl),
        .o_irq          (irq)
    );

    ipl_periph_model ipl_periph_model_inst (
        .i_mclk     (mclk),
        .i_req_cmd  (cmd),
        .i_core_lvl (core_lvl),
        .o_src_req  (src_req),
        .o_lvl_seen (lvl_seen)
    );

    task automatic complete_run;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Holds the request until pready is sampled high, then releases
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            $display("[FAIL] pready expected 1 seen %b", pready);
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 8000) begin
            err_count++;
            complete_run();
        end
    end

    initial begin
        logic [31:0] fv;
        logic [2:0]  lv;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        // Reset values, then writable bits only
        for (int i = 1; i < 5; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0, rd, er);
            chk("prio reset", rd, 32'h00000000);
            apb(1'b1, 8'(i * 4), 32'hFFFFFFFF, rd, er);
            apb(1'b0, 8'(i * 4), 32'h0, rd, er);
            chk("prio ones", rd, wmask[i]);
            apb(1'b1, 8'(i * 4), 32'h0, rd, er);
        end
        apb(1'b0, 8'h80, 32'h0, rd, er);
        chk("status reset", rd, 32'h00000000);
        apb(1'b0, 8'h84, 32'h0, rd, er);
        chk("mask reset", rd, 32'h00000000);
        apb(1'b0, 8'h40, 32'h0, rd, er);
        chk("unmapped data", rd, 32'h00000000);
        chk("unmapped err", {31'h0, er}, 32'h00000001);
        apb(1'b1, 8'h40, 32'hFFFFFFFF, rd, er);
        chk("unmapped wr err", {31'h0, er}, 32'h00000001);
        // Every source at every code, ending disabled
        for (int s = 0; s < 18; s++) begin
            for (int c = 3; c >= 0; c--) begin
                fv = 32'(c) << rpos[s];
                lv = (c == 0) ? 3'h0 : 3'(3'h1 << (c - 1));
                apb(1'b1, 8'(ridx[s] * 4), fv, rd, er);
                apb(1'b0, 8'(ridx[s] * 4), 32'h0, rd, er);
                chk("field", rd, fv);
                cmd[s] <= 1'b1;
                repeat (3) @(posedge mclk);
                chk("core level", {29'h0, core_lvl}, {29'h0, lv});
                @(posedge mclk);
                chk("core seen", {29'h0, lvl_seen}, {29'h0, lv});
                cmd[s] <= 1'b0;
                repeat (3) @(posedge mclk);
                chk("core idle", {29'h0, core_lvl}, 32'h00000000);
            end
        end
        apb(1'b0, 8'h80, 32'h0, rd, er);
        chk("status all", rd, 32'h0003FFFF);
        chk("irq masked", {31'h0, irq}, 32'h00000000);
        apb(1'b1, 8'h84, 32'h00000080, rd, er);
        repeat (2) @(posedge mclk);
        chk("irq unmasked", {31'h0, irq}, 32'h00000001);
        apb(1'b1, 8'h80, 32'h00000080, rd, er);
        repeat (2) @(posedge mclk);
        chk("irq cleared", {31'h0, irq}, 32'h00000000);
        apb(1'b0, 8'h80, 32'h0, rd, er);
        chk("status w1c", rd, 32'h0003FF7F);
        apb(1'b1, 8'h80, 32'h0003FFFF, rd, er);
        // Disabled source must not set status
        cmd[5] <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("off level", {29'h0, core_lvl}, 32'h00000000);
        apb(1'b0, 8'h80, 32'h0, rd, er);
        chk("off status", rd, 32'h00000000);
        cmd[5] <= 1'b0;
        // Mid-run reset must return a programmed field to off
        apb(1'b1, 8'h08, 32'h0000FFFF, rd, er);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        apb(1'b0, 8'h08, 32'h0, rd, er);
        chk("prio mid reset", rd, 32'h00000000);
        complete_run();
    end
endmodule
`default_nettype wire
